// *** rtl/sdgear_defines.vh ***
// constants for the step/direction input gearing block
`ifndef SDGEAR_DEFINES_VH
`define SDGEAR_DEFINES_VH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define SDG_GENCONF_IDX 8'h00
`define SDG_GEAR_IDX 8'h12
`define SDG_STARTVEL_IDX 8'h25
`define SDG_STARTACC_IDX 8'h2A
`define SDG_ACTPOS_IDX 8'h21
`define SDG_ACTVEL_IDX 8'h22
`define SDG_ACTACC_IDX 8'h23
`define SDG_TGTPOS_IDX 8'h37
`define SDG_STATUS_IDX 8'h38

// ----------------------------------------------------------------
// general configuration fields
// ----------------------------------------------------------------
`define SDG_MODE_LSB 6
`define SDG_MODE_MSB 7
`define SDG_POLDIR_BIT 8
`define SDG_INDIRECT_BIT 9
`define SDG_AUTOOFF_BIT 26

// ----------------------------------------------------------------
// step input modes
// ----------------------------------------------------------------
`define SDG_MODE_OFF 2'h0
`define SDG_MODE_RISE 2'h1
`define SDG_MODE_FALL 2'h2
`define SDG_MODE_BOTH 2'h3

// ----------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------
`define SDG_RST_WORD 32'h00000000
`define SDG_FRAC_W 24
`define SDG_PEND_W 16
`define SDG_MIN_STEP_GAP 64

`endif

// *** rtl/sdgear_top.v ***
// step/direction input unit with electronic gearing and hand-over
//
// Contract
// - mode 01 counts rising step input edges
// - mode 10 counts falling step input edges
// - mode 11 counts both step input edges
// - nonzero mode disables internal step generator
// - polarity 0: low direction input is negative
// - polarity 1: high direction input is negative
// - gearing factor is signed 8.24 value
// - add factor per step, overflow emits step
// - magnitudes from 2^-24 up to 127
// - multiple internal steps back to back
// - negative factor inverts derived direction
// - direct mode forces velocity zero unless substituted
// - auto switch-off reports start velocity, step direction
// - indirect mode runs ramp, position untouched
// - indirect overflow moves target by one
// - target direction from sign, polarity, input
// - return to 00 starts ramp at start velocity
// - hand-over carries time since last step
// - hand-over loads signed start acceleration
`include "sdgear_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module sdgear_top
(
    input wire i_mclk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_step_input_pin,
    input wire i_direction_input_pin,
    output wire o_step_output_pin,
    output wire o_step_dir,
    output wire o_int_stepgen_en,
    output wire o_ramp_run,
    output wire o_ramp_load,
    output wire [31:0] o_ramp_velocity,
    output wire [31:0] o_ramp_accel,
    output wire [31:0] o_ramp_phase
);

// ----------------------------------------------------------------
// registers
// ----------------------------------------------------------------
reg [31:0] genconf_r; // general configuration
reg [31:0] gear_r; // signed 8.24 gearing factor
reg [31:0] start_vel_r; // start velocity
reg [31:0] start_acc_r; // start acceleration, bit 31 sign
reg [31:0] actpos_r; // actual position
reg [31:0] tgtpos_r; // target position
reg [31:0] actvel_r; // reported internal velocity
reg [31:0] actacc_r; // internal acceleration
reg [31:0] prdata_r; // read data captured in setup
reg [2:0] step_sync_r; // two sync stages plus history
reg [1:0] dir_sync_r; // direction synchroniser
reg [`SDG_FRAC_W-1:0] frac_r; // accumulator remainder
reg [`SDG_PEND_W-1:0] pend_r; // internal steps still owed
reg pend_dir_r; // direction of owed steps, 1 = up
reg last_dir_r; // direction of the last internal step
reg step_out_r; // internal step pulse
reg [31:0] since_r; // cycles since last internal step
reg ramp_load_r; // one-cycle hand-over pulse
reg [31:0] phase_r; // step phase carried at hand-over
reg [1:0] mode_prev_r; // mode of previous cycle

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
wire [1:0] mode;
wire pol_dir;
wire indirect;
wire auto_off;
assign mode = genconf_r[`SDG_MODE_MSB:`SDG_MODE_LSB];
assign pol_dir = genconf_r[`SDG_POLDIR_BIT];
assign indirect = genconf_r[`SDG_INDIRECT_BIT];
assign auto_off = genconf_r[`SDG_AUTOOFF_BIT];

// two's complement negate, used for factor, velocity, accel
function [31:0] sdg_neg;
    input [31:0] v;
    begin
        sdg_neg = (~v) + 32'h00000001;
    end
endfunction

// word index from byte address; low bits must be zero
wire [7:0] idx;
wire aligned;
assign idx = i_paddr[9:2];
assign aligned = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0);

reg hit;
reg [31:0] rd_mux;
// read mux; unmapped reads return zero and flag an error
always @*
begin
    hit = aligned;
    rd_mux = `SDG_RST_WORD;
    case (idx)
        `SDG_GENCONF_IDX: rd_mux = genconf_r;
        `SDG_GEAR_IDX: rd_mux = gear_r;
        `SDG_STARTVEL_IDX: rd_mux = start_vel_r;
        `SDG_STARTACC_IDX: rd_mux = start_acc_r;
        `SDG_ACTPOS_IDX: rd_mux = actpos_r;
        `SDG_ACTVEL_IDX: rd_mux = actvel_r;
        `SDG_ACTACC_IDX: rd_mux = actacc_r;
        `SDG_TGTPOS_IDX: rd_mux = tgtpos_r;
        `SDG_STATUS_IDX: rd_mux = {15'h0000, pend_r, last_dir_r};
        default: hit = 1'b0;
    endcase
    if (!aligned)
        rd_mux = `SDG_RST_WORD;
end

// ----------------------------------------------------------------
// apb slave: zero wait states
// ----------------------------------------------------------------
wire acc_phase;
wire wr_en;
assign acc_phase = i_psel && i_penable;
assign wr_en = acc_phase && i_pwrite && hit;
assign o_pready = 1'b1;
assign o_pslverr = acc_phase && !hit;
assign o_prdata = prdata_r;

// read data sampled in setup, stable through the access phase
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
        prdata_r <= `SDG_RST_WORD;
    else if (i_psel && !i_penable)
        prdata_r <= rd_mux;
end

// software-owned configuration words
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        genconf_r <= `SDG_RST_WORD; // polarity 0 by default
        gear_r <= `SDG_RST_WORD;
        start_vel_r <= `SDG_RST_WORD;
        start_acc_r <= `SDG_RST_WORD;
    end
    else if (wr_en)
    begin
        if (idx == `SDG_GENCONF_IDX)
            genconf_r <= i_pwdata;
        if (idx == `SDG_GEAR_IDX)
            gear_r <= i_pwdata; // full 8.24 signed word
        if (idx == `SDG_STARTVEL_IDX)
            start_vel_r <= i_pwdata; // kept fresh by host
        if (idx == `SDG_STARTACC_IDX)
            start_acc_r <= i_pwdata;
    end
end

// ----------------------------------------------------------------
// input synchronisers and edge detection
// ----------------------------------------------------------------
// stage 0 is read only by stage 1
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        step_sync_r <= 3'h0;
        dir_sync_r <= 2'h0;
    end
    else
    begin
        step_sync_r <= {step_sync_r[1:0], i_step_input_pin};
        dir_sync_r <= {dir_sync_r[0], i_direction_input_pin};
    end
end

wire st_now;
wire st_old;
wire dir_s;
assign st_now = step_sync_r[1];
assign st_old = step_sync_r[2];
assign dir_s = dir_sync_r[1];

reg ext_step;
// edge qualification by mode
always @*
begin
    case (mode)
        `SDG_MODE_RISE: ext_step = st_now && !st_old;
        `SDG_MODE_FALL: ext_step = !st_now && st_old;
        `SDG_MODE_BOTH: ext_step = st_now ^ st_old;
        default: ext_step = 1'b0;
    endcase
end

// ----------------------------------------------------------------
// gearing accumulator
// ----------------------------------------------------------------
// positive when the input level differs from the polarity bit
wire dir_pos_in;
assign dir_pos_in = dir_s ^ pol_dir;
// negative factor flips the derived direction
wire step_up;
assign step_up = dir_pos_in ^ gear_r[31];
wire [31:0] gear_mag;
assign gear_mag = gear_r[31] ? sdg_neg(gear_r) : gear_r;

// magnitude 127 plus a remainder carries at most 128 steps
wire [31:0] acc_sum;
assign acc_sum = {8'h00, frac_r} + {1'b0, gear_mag[30:0]};
wire [7:0] n_new;
assign n_new = ext_step ? acc_sum[31:24] : 8'h00;

wire emit;
assign emit = (pend_r != {`SDG_PEND_W{1'b0}});

// owed steps are paid one per clock, no interpolation
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        frac_r <= {`SDG_FRAC_W{1'b0}};
        pend_r <= {`SDG_PEND_W{1'b0}};
        pend_dir_r <= 1'b0;
    end
    else
    begin
        if (ext_step)
        begin
            frac_r <= acc_sum[23:0]; // remainder kept
            pend_dir_r <= step_up;
        end
        // burst of steps when sum reaches two or more
        pend_r <= pend_r - {{(`SDG_PEND_W-1){1'b0}}, emit}
            + {8'h00, n_new};
    end
end

// ----------------------------------------------------------------
// internal steps, positions and step timing
// ----------------------------------------------------------------
wire [31:0] delta;
assign delta = pend_dir_r ? 32'h00000001 : 32'hFFFFFFFF;

wire tgt_wr;
assign tgt_wr = wr_en && (idx == `SDG_TGTPOS_IDX);
wire pos_wr;
assign pos_wr = wr_en && (idx == `SDG_ACTPOS_IDX);
wire [31:0] tgt_base;
assign tgt_base = tgt_wr ? i_pwdata : tgtpos_r;
wire [31:0] pos_base;
assign pos_base = pos_wr ? i_pwdata : actpos_r;

// hardware step lands on top of a same-cycle software write
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        actpos_r <= `SDG_RST_WORD;
        tgtpos_r <= `SDG_RST_WORD;
        step_out_r <= 1'b0;
        last_dir_r <= 1'b0;
        since_r <= `SDG_RST_WORD;
    end
    else
    begin
        step_out_r <= emit && !indirect;
        if (emit && indirect)
            tgtpos_r <= tgt_base + delta;
        else
            tgtpos_r <= tgt_base;
        if (emit && !indirect)
            actpos_r <= pos_base + delta; // direct mode only
        else
            actpos_r <= pos_base;
        if (emit)
        begin
            last_dir_r <= pend_dir_r;
            since_r <= `SDG_RST_WORD; // restart interval count
        end
        else if (since_r != 32'hFFFFFFFF)
            since_r <= since_r + 32'h00000001;
    end
end

assign o_step_output_pin = step_out_r;
assign o_step_dir = last_dir_r;
// internal generator only while no external mode is chosen
assign o_int_stepgen_en = (mode == `SDG_MODE_OFF);
assign o_ramp_run = (mode == `SDG_MODE_OFF) || indirect;

// ----------------------------------------------------------------
// velocity, acceleration and hand-over
// ----------------------------------------------------------------
wire [31:0] vsigned;
assign vsigned = last_dir_r ? start_vel_r : sdg_neg(start_vel_r);
wire [31:0] acc_mag;
assign acc_mag = {1'b0, start_acc_r[30:0]};
wire [31:0] asigned;
assign asigned = start_acc_r[31] ? sdg_neg(acc_mag) : acc_mag;

wire direct_on;
assign direct_on = (mode != `SDG_MODE_OFF) && !indirect;
// leaving direct stepping for mode 00 with switch-off armed
wire handover;
assign handover = (mode_prev_r != `SDG_MODE_OFF)
    && (mode == `SDG_MODE_OFF) && !indirect && auto_off;

// ramp arithmetic lives elsewhere; this only seeds its state
always @(posedge i_mclk or posedge i_rst)
begin
    if (i_rst)
    begin
        mode_prev_r <= `SDG_MODE_OFF;
        actvel_r <= `SDG_RST_WORD;
        actacc_r <= `SDG_RST_WORD;
        ramp_load_r <= 1'b0;
        phase_r <= `SDG_RST_WORD;
    end
    else
    begin
        mode_prev_r <= mode;
        ramp_load_r <= handover;
        if (handover)
        begin
            actvel_r <= vsigned; // start at start velocity
            actacc_r <= asigned; // signed start accel
            phase_r <= since_r; // keeps step interval even
        end
        else if (direct_on)
        begin
            if (auto_off)
                actvel_r <= vsigned; // substituted velocity
            else
                actvel_r <= `SDG_RST_WORD; // forced zero
            actacc_r <= `SDG_RST_WORD;
        end
    end
end

assign o_ramp_load = ramp_load_r;
assign o_ramp_velocity = actvel_r;
assign o_ramp_accel = actacc_r;
assign o_ramp_phase = phase_r;

endmodule // sdgear_top

`default_nettype wire

// *** verif/sdgear_properties.sv ***
// concurrent checks on the gearing block's ports
`timescale 1ns/100ps
`default_nettype none
`include "sdgear_defines.vh"
module sdgear_properties
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_step_input_pin,
    input wire logic i_direction_input_pin,
    input wire logic o_step_output_pin,
    input wire logic o_step_dir,
    input wire logic o_int_stepgen_en,
    input wire logic o_ramp_run,
    input wire logic o_ramp_load,
    input wire logic [31:0] o_ramp_velocity,
    input wire logic [31:0] o_ramp_accel,
    input wire logic [31:0] o_ramp_phase
);
    logic [31:0] cfg_r, gear_r, acc_r; // shadows of host words
    logic wr_ok; // aligned write in access phase
    assign wr_ok = i_psel && i_penable && i_pwrite && i_paddr[1:0] == 2'h0
        && i_paddr[11:10] == 2'h0;
    // ----------------------------------------------------------------
    // shadows follow host writes, so outputs can be tied to config
    // ----------------------------------------------------------------
    always @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg_r <= 32'h0;
            gear_r <= 32'h0;
            acc_r <= 32'h0;
        end
        else if (wr_ok)
        begin
            if (i_paddr[9:2] == `SDG_GENCONF_IDX) cfg_r <= i_pwdata;
            if (i_paddr[9:2] == `SDG_GEAR_IDX) gear_r <= i_pwdata;
            if (i_paddr[9:2] == `SDG_STARTACC_IDX) acc_r <= i_pwdata;
        end
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    sequence off_write_s; // host selects mode 00
        wr_ok && i_paddr[9:2] == `SDG_GENCONF_IDX && i_pwdata[7:6] == 2'h0;
    endsequence
    sequence handover_s; // from direct stepping, auto switch-off set
        off_write_s ##0 (cfg_r[7:6] != 2'h0 && !i_pwdata[9] && i_pwdata[26]);
    endsequence
    stepgen_mode_a: assert property (
        o_int_stepgen_en == (cfg_r[7:6] == 2'h0))
        else $error("internal step generator enable wrong");
    ramp_run_a: assert property (
        o_ramp_run == (cfg_r[7:6] == 2'h0 || cfg_r[9]))
        else $error("ramp run wrong");
    direct_step_a: assert property (
        o_step_output_pin |-> cfg_r[7:6] != 2'h0 && !cfg_r[9])
        else $error("step output outside direct mode");
    step_dir_a: assert property (
        o_step_output_pin |-> o_step_dir ==
        (i_direction_input_pin ^ cfg_r[8] ^ gear_r[31]))
        else $error("step direction wrong");
    rise_step_a: assert property (
        $rose(i_step_input_pin) && cfg_r[9:6] == 4'h1
        && gear_r == 32'h01000000 |-> ##[3:5] o_step_output_pin)
        else $error("rising edge gave no step");
    handover_load_a: assert property (handover_s |-> ##[1:3] o_ramp_load)
        else $error("no ramp load at hand-over");
    load_once_a: assert property (o_ramp_load |=> !o_ramp_load)
        else $error("ramp load longer than one cycle");
    load_accel_a: assert property (
        o_ramp_load |-> o_ramp_accel == (acc_r[31]
        ? 32'h0 - {1'b0, acc_r[30:0]} : {1'b0, acc_r[30:0]}))
        else $error("start acceleration sign wrong");
endmodule // sdgear_properties
bind sdgear_top sdgear_properties chk_u (.i_mclk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
    .i_step_input_pin, .i_direction_input_pin, .o_step_output_pin, .o_step_dir,
    .o_int_stepgen_en, .o_ramp_run, .o_ramp_load, .o_ramp_velocity,
    .o_ramp_accel, .o_ramp_phase);
`default_nettype wire

// *** verif/sdgear_stepsrc.sv ***
// external step/direction source model for the gearing bench
`timescale 1ns/100ps
`default_nettype none
module sdgear_stepsrc
(
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_edges,
    input wire logic [7:0] i_half,
    input wire logic i_dir,
    output logic o_step,
    output logic o_dir,
    output wire logic o_busy
);
    logic [7:0] left_r = 8'h00; // edges still owed
    logic [7:0] tick_r = 8'h00; // cycles to the next edge
    initial o_step = 1'b0;
    initial o_dir = 1'b0;
    assign o_busy = left_r != 8'h00;
    // ----------------------------------------------------------------
    // one toggle per half period; half >= 32 keeps like edges 64 apart
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_go)
        begin
            left_r <= i_edges;
            tick_r <= i_half;
            o_dir <= i_dir;
        end
        else if (o_busy && tick_r == 8'h01)
        begin
            o_step <= ~o_step;
            left_r <= left_r - 8'h01;
            tick_r <= i_half;
        end
        else if (o_busy)
            tick_r <= tick_r - 8'h01;
    end
endmodule // sdgear_stepsrc
`default_nettype wire

// *** verif/step_dir_input_gearing_bench.sv ***
// self-checking bench for the step/direction gearing block
`timescale 1ns/100ps
`default_nettype none
`include "sdgear_defines.vh"
module step_dir_input_gearing_bench;
    logic i_mclk = 1'b0; // 25 MHz clock
    logic i_rst = 1'b1; // held three edges
    logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
    logic go = 1'b0, sdir = 1'b0; // step source controls
    logic [7:0] ned = 8'h00, half = 8'h08;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0, q, p0;
    logic e; // slave error of last transfer
    wire logic [31:0] o_prdata, o_ramp_velocity, o_ramp_accel, o_ramp_phase;
    wire logic o_pready, o_pslverr, o_step_output_pin, o_step_dir, bsy;
    wire logic o_int_stepgen_en, o_ramp_run, o_ramp_load;
    wire logic i_step_input_pin, i_direction_input_pin;
    int err_total = 0, total_checks = 0, cyc = 0, nst = 0, n0, k, i;
    sdgear_top dut_u (.i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite,
        .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_step_input_pin, .i_direction_input_pin, .o_step_output_pin,
        .o_step_dir, .o_int_stepgen_en, .o_ramp_run, .o_ramp_load,
        .o_ramp_velocity, .o_ramp_accel, .o_ramp_phase);
    sdgear_stepsrc src_u (.i_clk(i_mclk), .i_go(go), .i_edges(ned),
        .i_half(half), .i_dir(sdir), .o_step(i_step_input_pin),
        .o_dir(i_direction_input_pin), .o_busy(bsy));
    always #20 i_mclk = ~i_mclk;
    // ----------------------------------------------------------------
    // step pulse counter and hang guard
    // ----------------------------------------------------------------
    always @(posedge i_mclk)
    begin
        cyc++;
        nst += (o_step_output_pin === 1'b1);
        if (cyc == 12000)
        begin
            err_total++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x)
        begin
            err_total++;
            $display("MISMATCH %0t seen %h want %h", $time, s, x);
        end
    endtask
    // apb transfer: request held until pready is seen high
    task apb(input logic w, input logic [7:0] ix, input logic [31:0] d);
        @(posedge i_mclk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {2'h0, ix, 2'h0};
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        @(posedge i_mclk);
        // no wait-state count assumed; only the cycle guard ends this
        while (o_pready !== 1'b1) @(posedge i_mclk);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    // n source edges, then time for the longest burst to drain
    task pulse(input logic [7:0] n, input logic d);
        @(posedge i_mclk);
        ned <= n;
        sdir <= d;
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        @(posedge i_mclk);
        while (bsy === 1'b1) @(posedge i_mclk);
        repeat (150) @(posedge i_mclk);
    endtask
    function logic [31:0] cf(input logic [1:0] m, input logic p, input logic t,
        input logic a);
        cf = {5'h0, a, 16'h0, t, p, m, 6'h0};
    endfunction
    task s_regs;
        apb(1'b0, `SDG_GENCONF_IDX, 32'h0);
        chk(q, `SDG_RST_WORD);
        apb(1'b1, `SDG_GEAR_IDX, 32'h89ABCDEF);
        apb(1'b0, `SDG_GEAR_IDX, 32'h0);
        chk(q, 32'h89ABCDEF);
        apb(1'b0, 8'h7F, 32'h0);
        chk(q, 32'h0);
        chk(e, 1'b1);
    endtask
    task s_modes;
        apb(1'b1, `SDG_GEAR_IDX, 32'h01000000);
        for (i = 1; i < 4; i++)
        begin
            apb(1'b1, `SDG_GENCONF_IDX, cf(i[1:0], 1'b0, 1'b0, 1'b0));
            n0 = nst;
            pulse(8'h04, 1'b1);
            chk(nst - n0, (i == 3) ? 4 : 2);
            chk(o_int_stepgen_en, 1'b0);
            chk(o_ramp_run, 1'b0);
            apb(1'b0, `SDG_ACTVEL_IDX, 32'h0);
            chk(q, 32'h0);
        end
    endtask
    task s_gear;
        logic [31:0] g [4] = '{32'h00800000, 32'h03000000, 32'h7F000000,
            32'h00000001};
        int ne [4] = '{4, 2, 1, 2};
        int ex [4] = '{2, 6, 127, 0};
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, `SDG_GEAR_IDX, g[i]);
            n0 = nst;
            pulse(ne[i][7:0], 1'b1);
            chk(nst - n0, ex[i]);
        end
    endtask
    task s_dir;
        // bit 2 direction input, bit 1 polarity, bit 0 negative factor
        logic [2:0] t [4] = '{3'h0, 3'h6, 3'h2, 3'h5};
        int ex [4] = '{-2, -2, 2, -2};
        for (i = 0; i < 4; i++)
        begin
            apb(1'b1, `SDG_GEAR_IDX, t[i][0] ? 32'hFF000000 : 32'h01000000);
            apb(1'b1, `SDG_GENCONF_IDX, cf(2'h3, t[i][1], 1'b0, 1'b0));
            apb(1'b0, `SDG_ACTPOS_IDX, 32'h0);
            p0 = q;
            pulse(8'h02, t[i][2]);
            apb(1'b0, `SDG_ACTPOS_IDX, 32'h0);
            chk(q - p0, ex[i]);
            chk(o_step_dir, ex[i] > 0);
        end
    endtask
    task s_ind;
        apb(1'b1, `SDG_GEAR_IDX, 32'h01000000);
        apb(1'b1, `SDG_GENCONF_IDX, cf(2'h1, 1'b0, 1'b1, 1'b0));
        apb(1'b1, `SDG_TGTPOS_IDX, 32'h0);
        apb(1'b0, `SDG_ACTPOS_IDX, 32'h0);
        p0 = q;
        n0 = nst;
        half <= 8'h28;
        pulse(8'h06, 1'b1);
        apb(1'b0, `SDG_TGTPOS_IDX, 32'h0);
        chk(q, 32'h3);
        pulse(8'h04, 1'b0);
        apb(1'b0, `SDG_TGTPOS_IDX, 32'h0);
        chk(q, 32'h1);
        apb(1'b0, `SDG_ACTPOS_IDX, 32'h0);
        chk(q, p0);
        chk(nst - n0, 0);
        chk(o_ramp_run, 1'b1);
        half <= 8'h08;
    endtask
    task s_hand;
        apb(1'b1, `SDG_STARTVEL_IDX, 32'h64);
        apb(1'b1, `SDG_STARTACC_IDX, 32'h80000010);
        apb(1'b1, `SDG_GENCONF_IDX, cf(2'h1, 1'b0, 1'b0, 1'b1));
        pulse(8'h02, 1'b1);
        apb(1'b0, `SDG_ACTVEL_IDX, 32'h0);
        chk(q, 32'h64);
        apb(1'b1, `SDG_GENCONF_IDX, cf(2'h0, 1'b0, 1'b0, 1'b1));
        for (k = 0; k < 20 && o_ramp_load !== 1'b1; k++) @(posedge i_mclk);
        chk(o_ramp_load, 1'b1);
        chk(o_ramp_velocity, 32'h64);
        chk(o_ramp_accel, 32'hFFFFFFF0);
        chk(o_ramp_phase != 32'h0, 1'b1);
        chk(o_int_stepgen_en, 1'b1);
    endtask
    initial
    begin
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        s_regs();
        s_modes();
        s_gear();
        s_dir();
        s_ind();
        s_hand();
        print_verdict();
    end
endmodule // step_dir_input_gearing_bench
`default_nettype wire
